// ---- verilog/ppwm_pkg.sv ----
// Constants for the pulse period / width measurement timer
package ppwm_pkg;
    localparam int          CNT_W        = 16;
    // APB byte addresses
    localparam logic [7:0]  ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  ADDR_MODE    = 8'h04;
    localparam logic [7:0]  ADDR_TIMER   = 8'h08;
    localparam logic [7:0]  ADDR_STATUS  = 8'h0C;
    localparam logic [7:0]  ADDR_IRQ_EN  = 8'h10;
    localparam logic [7:0]  ADDR_IRQ_CLR = 8'h14;
    // CTRL fields
    localparam int          CTRL_START   = 0;
    // MODE fields
    localparam int          MODE_MEAS    = 0;  // 0 period, 1 width
    localparam int          MODE_CSEL_LO = 4;
    localparam int          MODE_CSEL_HI = 5;
    localparam logic [5:0]  MODE_MASK    = 6'h31;
    // STATUS / IRQ fields
    localparam int          ST_EDGE      = 0;
    localparam int          ST_OVF_IRQ   = 1;
    localparam int          ST_MODE_CHG  = 2;
    localparam int          ST_OVF_FLAG  = 3;
    localparam int          ST_VALID     = 4;
    localparam int          IRQ_W        = 3;
    // Count source division ratios
    localparam logic [1:0]  CSEL_F1      = 2'h0;
    localparam logic [1:0]  CSEL_F8      = 2'h1;
    localparam logic [1:0]  CSEL_F32     = 2'h2;
    localparam logic [1:0]  CSEL_SUBCLOCK_DIV32    = 2'h3;
    localparam logic [4:0]  DIV8_LAST    = 5'h07;
    localparam logic [4:0]  DIV32_LAST   = 5'h1F;
    localparam logic [15:0] CNT_ZERO     = 16'h0000;
    localparam logic [15:0] CNT_MAX      = 16'hFFFF;
    typedef enum logic [1:0] {
        PPWM_IDLE  = 2'b00,
        PPWM_ARMED = 2'b01,
        PPWM_RUN   = 2'b11
    } ppwm_state_t;
endpackage

// ---- verilog/ppwm_timer.sv ----
// Pulse period / pulse width measurement timer with APB register access
// Function
// - Count up; each effective edge copies count to reload, restarts from zero.
// - Start flag 1 runs the counter, 0 halts it.
// - Each effective edge raises a request except the first after start.
// - Overflow raises request and sets flag; mode write while running clears it.
// - Timer register read returns reload register, not the running count.
// - Result invalid until the second effective edge after start.
// - Software writes to the timer register do nothing.
// - Changing measurement mode while running raises the timer request.
// - Two-bit source select: 00 f1, 01 f8, 10 f32, 11 subclock/32.
`timescale 1ns/100ps
module ppwm_timer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        measure_pulse_input,
    input  wire logic        subclock_tick,
    output logic             irq
);
    localparam int W = ppwm_pkg::CNT_W;

    // Synchroniser and edge detect
    logic       sync1_r, sync2_r, prev_r;
    logic       sub1_r, sub2_r, subp_r;
    logic [2:0] sy_nxt;
    logic [2:0] su_nxt;
    // Registers
    logic       start_r, start_nxt;
    logic [5:0] mode_r, mode_nxt;
    logic [ppwm_pkg::IRQ_W-1:0] ien_r, ien_nxt;
    logic [ppwm_pkg::IRQ_W-1:0] ist_r, ist_nxt;
    logic       ovf_r, ovf_nxt;
    logic       valid_r, valid_nxt;
    logic [W-1:0] cnt_r, cnt_nxt, rld_r, rld_nxt;
    logic [4:0] pre_r, pre_nxt;
    ppwm_pkg::ppwm_state_t st_r, st_nxt;
    logic [31:0] prdata_nxt;
    logic        irq_nxt;
    logic        pready_nxt;
    logic        pslverr_nxt;

    logic wr, rd, edge_ev, tick, sub_ev, mapped;
    logic go_ev, ovf_ev, chg_ev;
    logic [7:0] wa;

    always_comb begin
        sy_nxt = {sync1_r, measure_pulse_input, sync2_r};
        su_nxt = {sub1_r, subclock_tick, sub2_r};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r  <= 1'b0;
            sub1_r  <= 1'b0;
            sub2_r  <= 1'b0;
            subp_r  <= 1'b0;
        end else begin
            sync1_r <= sy_nxt[1];
            sync2_r <= sy_nxt[2];
            prev_r  <= sy_nxt[0];
            sub1_r  <= su_nxt[1];
            sub2_r  <= su_nxt[2];
            subp_r  <= su_nxt[0];
        end
    end

    // Count source select field of a mode word
    function automatic logic [1:0] csel_of(input logic [5:0] mode);
        csel_of = mode[ppwm_pkg::MODE_CSEL_HI:ppwm_pkg::MODE_CSEL_LO];
    endfunction

    // One count step of the selected source; subclock path also needs its tick
    function automatic logic tick_of(input logic [1:0] csel,
                                     input logic [4:0] pre,
                                     input logic       sub);
        tick_of = 1'b0;
        unique case (csel)
            ppwm_pkg::CSEL_F1:   tick_of = 1'b1;
            ppwm_pkg::CSEL_F8:   tick_of = (pre[2:0] == ppwm_pkg::DIV8_LAST[2:0]);
            ppwm_pkg::CSEL_F32:  tick_of = (pre == ppwm_pkg::DIV32_LAST);
            ppwm_pkg::CSEL_SUBCLOCK_DIV32: tick_of = sub && (pre == ppwm_pkg::DIV32_LAST);
        endcase
    endfunction

    // Period mode takes rising edges only, width mode both
    function automatic logic edge_of(input logic width,
                                     input logic now,
                                     input logic was);
        edge_of = width ? (now ^ was) : (now && !was);
    endfunction

    // Word-aligned map; any other address is refused
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == ppwm_pkg::ADDR_CTRL)   || (a == ppwm_pkg::ADDR_MODE)
                 || (a == ppwm_pkg::ADDR_TIMER)  || (a == ppwm_pkg::ADDR_STATUS)
                 || (a == ppwm_pkg::ADDR_IRQ_EN) || (a == ppwm_pkg::ADDR_IRQ_CLR);
    endfunction

    // Write strobe of one register
    function automatic logic wr_to(input logic       w,
                                   input logic [7:0] a,
                                   input logic [7:0] reg_a);
        wr_to = w && (a == reg_a);
    endfunction

    // Bus decode and event detection
    always_comb begin
        wa      = paddr;
        // Write lands at the completing edge; read is sampled one edge earlier
        wr      = psel && penable && pwrite && pready;
        rd      = psel && penable && !pwrite && !pready;
        mapped  = is_mapped(wa);
        sub_ev  = sub2_r && !subp_r;
        // Synchronised pin, one capture per edge
        edge_ev = start_r && edge_of(mode_r[ppwm_pkg::MODE_MEAS], sync2_r, prev_r);
        tick    = tick_of(csel_of(mode_r), pre_r, sub_ev);
        go_ev   = wr_to(wr, wa, ppwm_pkg::ADDR_CTRL) && pwdata[ppwm_pkg::CTRL_START]
               && !start_r;
        // Edge wins over a tick in the same cycle
        ovf_ev  = start_r && tick && !edge_ev && (cnt_r == ppwm_pkg::CNT_MAX);
        chg_ev  = wr_to(wr, wa, ppwm_pkg::ADDR_MODE) && start_r
               && (pwdata[ppwm_pkg::MODE_MEAS] != mode_r[ppwm_pkg::MODE_MEAS]);
    end

    // Control group: start flag, mode, enables and arming state
    always_comb begin
        start_nxt = start_r;
        mode_nxt  = mode_r;
        ien_nxt   = ien_r;
        st_nxt    = st_r;
        if (wr_to(wr, wa, ppwm_pkg::ADDR_CTRL)) begin
            start_nxt = pwdata[ppwm_pkg::CTRL_START];
        end
        if (wr_to(wr, wa, ppwm_pkg::ADDR_MODE)) begin
            mode_nxt = pwdata[5:0] & ppwm_pkg::MODE_MASK;
        end
        if (wr_to(wr, wa, ppwm_pkg::ADDR_IRQ_EN)) begin
            ien_nxt = pwdata[ppwm_pkg::IRQ_W-1:0];
        end
        // Timer register writes decode to nothing
        unique case (st_r)
            ppwm_pkg::PPWM_IDLE: begin
                if (go_ev) begin
                    st_nxt = ppwm_pkg::PPWM_ARMED;
                end
            end
            ppwm_pkg::PPWM_ARMED: begin
                if (edge_ev) begin
                    st_nxt = ppwm_pkg::PPWM_RUN; // First edge raises no request
                end
            end
            ppwm_pkg::PPWM_RUN: begin
                st_nxt = st_r;
            end
            default: st_nxt = ppwm_pkg::PPWM_IDLE;
        endcase
        if (wr_to(wr, wa, ppwm_pkg::ADDR_CTRL) && !pwdata[ppwm_pkg::CTRL_START]) begin
            st_nxt = ppwm_pkg::PPWM_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_r <= 1'b0;
            mode_r  <= 6'h00;
            ien_r   <= '0;
            st_r    <= ppwm_pkg::PPWM_IDLE;
        end else begin
            start_r <= start_nxt;
            mode_r  <= mode_nxt;
            ien_r   <= ien_nxt;
            st_r    <= st_nxt;
        end
    end

    // Counter group: prescaler, up-counter and reload register
    always_comb begin
        cnt_nxt = cnt_r;
        rld_nxt = rld_r;
        pre_nxt = pre_r;
        // Prescaler idles at zero while stopped so each run starts on a fresh phase
        if (!start_r) begin
            pre_nxt = 5'h00;
        end else if (csel_of(mode_r) != ppwm_pkg::CSEL_SUBCLOCK_DIV32 || sub_ev) begin
            pre_nxt = pre_r + 5'h01;
        end
        if (go_ev) begin
            cnt_nxt = ppwm_pkg::CNT_ZERO;
        end
        if (edge_ev) begin
            rld_nxt = cnt_r;
            cnt_nxt = ppwm_pkg::CNT_ZERO;
            pre_nxt = 5'h00;
        end else if (start_r && tick) begin
            cnt_nxt = cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= ppwm_pkg::CNT_ZERO;
            rld_r <= ppwm_pkg::CNT_ZERO;
            pre_r <= 5'h00;
        end else begin
            cnt_r <= cnt_nxt;
            rld_r <= rld_nxt;
            pre_r <= pre_nxt;
        end
    end

    // Status group: sticky requests, overflow flag and result valid
    always_comb begin
        ist_nxt   = ist_r;
        ovf_nxt   = ovf_r;
        valid_nxt = valid_r;
        // Clears first so that a hardware set in the same cycle wins
        if (wr_to(wr, wa, ppwm_pkg::ADDR_IRQ_CLR)) begin
            ist_nxt = ist_r & ~pwdata[ppwm_pkg::IRQ_W-1:0];
        end
        if (wr_to(wr, wa, ppwm_pkg::ADDR_MODE) && start_r) begin
            ovf_nxt = 1'b0;
        end
        if (go_ev) begin
            valid_nxt = 1'b0;
        end
        if (chg_ev) begin
            ist_nxt[ppwm_pkg::ST_MODE_CHG] = 1'b1;
        end
        if (edge_ev && st_r == ppwm_pkg::PPWM_RUN) begin
            ist_nxt[ppwm_pkg::ST_EDGE] = 1'b1;
            valid_nxt = 1'b1;
        end
        if (ovf_ev) begin
            ovf_nxt = 1'b1;
            ist_nxt[ppwm_pkg::ST_OVF_IRQ] = 1'b1;
        end
        irq_nxt = |(ist_nxt & ien_nxt);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist_r   <= '0;
            ovf_r   <= 1'b0;
            valid_r <= 1'b0;
            irq     <= 1'b0;
        end else begin
            ist_r   <= ist_nxt;
            ovf_r   <= ovf_nxt;
            valid_r <= valid_nxt;
            irq     <= irq_nxt;
        end
    end

    // Bus group: one wait state, then the answer stands for a single cycle
    always_comb begin
        prdata_nxt  = 32'h0000_0000;
        pready_nxt  = psel && penable && !pready;
        pslverr_nxt = psel && penable && !pready && !mapped;
        if (rd) begin
            unique case (wa)
                ppwm_pkg::ADDR_CTRL:   prdata_nxt = {31'h0, start_r};
                ppwm_pkg::ADDR_MODE:   prdata_nxt = {26'h0, mode_r};
                ppwm_pkg::ADDR_TIMER:  prdata_nxt = {16'h0, rld_r};
                ppwm_pkg::ADDR_STATUS: prdata_nxt = {27'h0, valid_r, ovf_r, ist_r};
                ppwm_pkg::ADDR_IRQ_EN: prdata_nxt = {29'h0, ien_r};
                default:               prdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= prdata_nxt;
            pready  <= pready_nxt;
            pslverr <= pslverr_nxt;
        end
    end
endmodule

// ---- tb/ppwm_timer_props.sv ----
// Checker on the timer's bus and interrupt pins
`timescale 1ns/100ps
module ppwm_timer_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_wait; $rose(penable) && psel |=> pready; endproperty
    a_wait: assert property (p_wait) else $error("no ready after one wait state");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("ready held too long");
    property p_err;
        pready && (paddr > 8'h14 || paddr[1:0] != 2'h0) |-> pslverr && prdata == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_ok; pready && paddr <= 8'h14 && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("mapped access refused");
    property p_lone; pslverr |-> pready; endproperty
    a_lone: assert property (p_lone) else $error("error without ready");
    property p_tmr;
        pready && !pwrite && paddr == ppwm_pkg::ADDR_TIMER |-> prdata[31:16] == 16'h0;
    endproperty
    a_tmr: assert property (p_tmr) else $error("timer read too wide");
    property p_st;
        pready && !pwrite && paddr == ppwm_pkg::ADDR_STATUS |-> prdata[31:5] == 27'h0;
    endproperty
    a_st: assert property (p_st) else $error("status upper bits set");
    // Enable lands at the completing edge, one after the first access edge; irq registers from it at that same edge
    property p_mask;
        psel && penable && !pready && pwrite && paddr == ppwm_pkg::ADDR_IRQ_EN
            && pwdata[2:0] == 3'h0 |-> ##2 !irq;
    endproperty
    a_mask: assert property (p_mask) else $error("irq not masked");
endmodule
bind ppwm_timer ppwm_timer_props u_ppwm_timer_props (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq);

// ---- tb/ppwm_pulse_src.sv ----
// Model of the measured pulse: programmable high and low lengths in clocks
`timescale 1ns/100ps
module ppwm_pulse_src (
    input  wire logic        clk,
    input  wire logic        run,
    input  wire logic [15:0] hi_len,
    input  wire logic [15:0] lo_len,
    output logic             pulse
);
    logic [15:0] cnt = 16'h0000;
    initial pulse = 1'b0;
    // Stopped source holds its level, as a quiet line would
    always @(posedge clk) begin
        if (run && cnt + 16'h0001 >= (pulse ? hi_len : lo_len)) begin
            pulse <= ~pulse;
            cnt   <= 16'h0000;
        end else if (run) begin
            cnt <= cnt + 16'h0001;
        end
    end
endmodule

// ---- tb/tb_ppwm_timer.sv ----
// Self-checking bench for the measurement timer
`timescale 1ns/100ps
module tb_ppwm_timer;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, run, pulse, sub_r;
    logic [7:0]  paddr, cyc;
    logic [31:0] pwdata, prdata, lo_v, hi_v;
    logic [15:0] hi_len, lo_len;
    logic [31:0] q_lo[$], q_hi[$];
    int          fails, total_checks, h, l, m, p;
    localparam int DV [4] = '{1, 8, 32, 256};
    ppwm_timer u_ppwm_timer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .measure_pulse_input(pulse), .subclock_tick(sub_r), .irq);
    ppwm_pulse_src u_ppwm_pulse_src (.clk(pclk), .run, .hi_len, .lo_len, .pulse);
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // Subclock tick every 8 clocks, so one subclock/32 step is 256 clocks
    always @(posedge pclk) begin
        cyc   <= cyc + 8'h01;
        sub_r <= cyc[2];
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
        q_lo.push_back(lo);
        q_hi.push_back(hi);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic wait_irq(input int n);
        repeat (n) if (irq !== 1'b1) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
    endtask
    // Read results against the oldest note; a range covers prescaler phase
    always @(posedge pclk) if (psel && penable && pready === 1'b1 && !pwrite) begin
        lo_v = q_lo.pop_front();
        hi_v = q_hi.pop_front();
        if (lo_v == hi_v) chk(prdata, lo_v);
        else chk(32'(prdata >= lo_v && prdata <= hi_v), 32'h1);
    end
    initial begin
        {presetn, psel, penable, pwrite, run, sub_r} = 6'h00;
        {paddr, pwdata, cyc, hi_len, lo_len} = '0;
        void'($urandom(91));
        h = 20 + $urandom % 40;
        l = h + 5 + $urandom % 20;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(ppwm_pkg::ADDR_STATUS, 32'h0, 32'h0);
        rd(8'h20, 32'h0, 32'h0);
        apb(1'b1, ppwm_pkg::ADDR_IRQ_EN, 32'h7);
        apb(1'b1, ppwm_pkg::ADDR_CTRL, 32'h1);
        repeat (65000) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        wait_irq(1000);
        rd(ppwm_pkg::ADDR_STATUS, 32'h0A, 32'h0A);
        apb(1'b1, ppwm_pkg::ADDR_MODE, 32'h0);
        rd(ppwm_pkg::ADDR_STATUS, 32'h02, 32'h02);
        run <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            m = (c < 2) ? 1 : (c == 2) ? 4 : 16;
            hi_len <= 16'(h * m);
            lo_len <= 16'(l * m);
            apb(1'b1, ppwm_pkg::ADDR_CTRL, 32'h0);
            apb(1'b1, ppwm_pkg::ADDR_IRQ_CLR, 32'h7);
            apb(1'b1, ppwm_pkg::ADDR_MODE, 32'(c << 4));
            apb(1'b1, ppwm_pkg::ADDR_CTRL, 32'h1);
            wait_irq(8 * (h + l) * m);
            p = (h + l) * m / DV[c];
            rd(ppwm_pkg::ADDR_STATUS, 32'h11, 32'h11);
            if (c == 0) apb(1'b1, ppwm_pkg::ADDR_TIMER, 32'h1234);
            rd(ppwm_pkg::ADDR_TIMER, 32'(p - 1), 32'(c ? p + 1 : p - 1));
        end
        apb(1'b1, ppwm_pkg::ADDR_CTRL, 32'h0);
        hi_len <= 16'(h);
        lo_len <= 16'(l);
        apb(1'b1, ppwm_pkg::ADDR_MODE, 32'h0);
        apb(1'b1, ppwm_pkg::ADDR_CTRL, 32'h1);
        apb(1'b1, ppwm_pkg::ADDR_IRQ_CLR, 32'h7);
        apb(1'b1, ppwm_pkg::ADDR_MODE, 32'h1);
        repeat (4 * (h + l)) @(posedge pclk);
        rd(ppwm_pkg::ADDR_STATUS, 32'h15, 32'h15);
        rd(ppwm_pkg::ADDR_TIMER, 32'(h - 1), 32'(l - 1));
        apb(1'b1, ppwm_pkg::ADDR_IRQ_EN, 32'h0);
        repeat (4) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        test_done();
    end
    initial begin
        #500000;
        chk(32'h0, 32'h1);
        test_done();
    end
endmodule
